// ===== rtl/scc_pkg.sv
// package: constants, register map and carrier types for the caption inserter
package scc_pkg;
  // Notes on behaviour
  // - caption data goes on line 21 of odd fields and line 284 of even fields.
  // - each caption line starts with seven run-in sine cycles locked to bit timing.
  // - after run-in, two bit periods at blanking, then one start bit high.
  // - sixteen payload bits follow: two bytes, seven data bits plus odd parity.
  // - odd-field bytes come from the caption byte registers at caption_byte_lo and caption_byte_hi.
  // - even-field line 284 bytes come from the extended registers at extended_caption_byte_lo and extended_caption_byte_hi.
  // - run-in waveform and bit timing are generated inside the block.
  // - while enabled, pixel input on line 21 of odd fields and line 284 of even fields is replaced by caption.
  // - single two-byte buffer; registers go out on the next caption line.

  // ----------------------------------------
  // register map (byte addresses = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] SCC_IDX_EXT_LO = 8'h91;
  localparam logic [7:0] SCC_IDX_EXT_HI = 8'h92;
  localparam logic [7:0] SCC_IDX_CAP_LO = 8'h93;
  localparam logic [7:0] SCC_IDX_CAP_HI = 8'h94;
  localparam logic [7:0] SCC_IDX_CTRL = 8'h95;
  localparam logic [7:0] SCC_IDX_STATUS = 8'h96;
  localparam logic [7:0] SCC_BYTE_RST = 8'h00;
  localparam int SCC_CTRL_EN_BIT = 0;
  localparam logic [31:0] SCC_UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------
  // video timing
  // ----------------------------------------
  localparam logic [9:0] SCC_LINE_ODD = 10'd21;
  localparam logic [9:0] SCC_LINE_EVEN = 10'd284;
  localparam int SCC_CLK_HZ = 200_000_000;
  localparam int SCC_BIT_HZ = 503_496;
  localparam int SCC_BIT_CYC = SCC_CLK_HZ / SCC_BIT_HZ;
  localparam logic [11:0] SCC_BIT_LAST = 12'(SCC_BIT_CYC - 1);
  localparam int SCC_START_NS = 10_500;
  localparam logic [11:0] SCC_START_CYC = 12'((SCC_START_NS * 200 + 999) / 1000);
  localparam logic [4:0] SCC_RUNIN_HALF = 5'd14;
  localparam logic [4:0] SCC_GAP_BITS = 5'd2;
  localparam logic [4:0] SCC_DATA_BITS = 5'd16;
  localparam logic [9:0] SCC_LVL_BLANK = 10'h0f0;
  localparam logic [9:0] SCC_LVL_HIGH = 10'h2d0;
  localparam logic [9:0] SCC_LVL_MID = 10'h1e0;
  localparam logic [9:0] SCC_LVL_AMP = 10'h0f0;

  typedef struct packed {
    logic [9:0] line;
    logic odd_field;
    logic active;
    logic [9:0] data;
  } scc_pix_s;

  typedef enum logic [4:0] {
    SCC_IDLE = 5'b00001,
    SCC_WAIT = 5'b00010,
    SCC_RUNIN = 5'b00100,
    SCC_GAP = 5'b01000,
    SCC_DATA = 5'b10000
  } scc_state_e;
endpackage

// ===== rtl/scc_inserter.sv
// caption inserter: avalon register slave, line detection and caption serializer
module scc_inserter
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire scc_pix_s pix_i,
  input wire logic line_start_i,
  output logic [9:0] video_o,
  output logic caption_active_o
);

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic [7:0] ext_lo_r, ext_lo_nxt, ext_hi_r, ext_hi_nxt;
  logic [7:0] cap_lo_r, cap_lo_nxt, cap_hi_r, cap_hi_nxt;
  logic en_r, en_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  scc_state_e st_r, st_nxt;
  logic field_odd_r, field_odd_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    return a == idx;
  endfunction

  // one wait state on every access; write lands and read data stands on the edge
  // where waitrequest is sampled low, never while the master is still held off
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o = rd_r;

  always_comb begin
    logic wr;
    wr = avs_write_i & ack_r & avs_byteenable_i[0];
    ext_lo_nxt = ext_lo_r;
    ext_hi_nxt = ext_hi_r;
    cap_lo_nxt = cap_lo_r;
    cap_hi_nxt = cap_hi_r;
    en_nxt = en_r;
    ack_nxt = (avs_read_i | avs_write_i) & ~ack_r;
    rd_nxt = rd_r;
    if (wr && hit(avs_address_i, SCC_IDX_EXT_LO)) ext_lo_nxt = avs_writedata_i[7:0];
    if (wr && hit(avs_address_i, SCC_IDX_EXT_HI)) ext_hi_nxt = avs_writedata_i[7:0];
    if (wr && hit(avs_address_i, SCC_IDX_CAP_LO)) cap_lo_nxt = avs_writedata_i[7:0];
    if (wr && hit(avs_address_i, SCC_IDX_CAP_HI)) cap_hi_nxt = avs_writedata_i[7:0];
    if (wr && hit(avs_address_i, SCC_IDX_CTRL)) en_nxt = avs_writedata_i[SCC_CTRL_EN_BIT];
    if (avs_read_i && !ack_r) begin
      unique case (avs_address_i)
        SCC_IDX_EXT_LO: rd_nxt = {24'h000000, ext_lo_r};
        SCC_IDX_EXT_HI: rd_nxt = {24'h000000, ext_hi_r};
        SCC_IDX_CAP_LO: rd_nxt = {24'h000000, cap_lo_r};
        SCC_IDX_CAP_HI: rd_nxt = {24'h000000, cap_hi_r};
        SCC_IDX_CTRL: rd_nxt = {31'h00000000, en_r};
        SCC_IDX_STATUS: rd_nxt = {26'h0000000, field_odd_r, st_r};
        default: rd_nxt = SCC_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_lo_r <= SCC_BYTE_RST;
      ext_hi_r <= SCC_BYTE_RST;
      cap_lo_r <= SCC_BYTE_RST;
      cap_hi_r <= SCC_BYTE_RST;
      en_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      ext_lo_r <= ext_lo_nxt;
      ext_hi_r <= ext_hi_nxt;
      cap_lo_r <= cap_lo_nxt;
      cap_hi_r <= cap_hi_nxt;
      en_r <= en_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------
  // caption serializer
  // ----------------------------------------
  logic [11:0] cyc_r, cyc_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [9:0] vid_r, vid_nxt;
  logic act_r, act_nxt;
  logic cap_line;
  logic [9:0] wave;

  function automatic logic [7:0] with_parity(input logic [7:0] b);
    return {~^b[6:0], b[6:0]};
  endfunction

  assign cap_line = en_r & ((pix_i.odd_field & pix_i.line == SCC_LINE_ODD) |
                    (~pix_i.odd_field & pix_i.line == SCC_LINE_EVEN));

  // run-in: triangle-shaped approximation of a sine, one cycle per bit period
  always_comb begin
    logic [11:0] ph;
    ph = (cyc_r < 12'(SCC_BIT_CYC / 2)) ? cyc_r : 12'(SCC_BIT_LAST - cyc_r);
    // 32-bit product: a 12-bit one would wrap and flatten the run-in
    wave = 10'(int'(SCC_LVL_BLANK) + (int'(ph) * int'(SCC_LVL_AMP)) / (SCC_BIT_CYC / 2));
  end

  always_comb begin
    st_nxt = st_r;
    cyc_nxt = cyc_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    field_odd_nxt = field_odd_r;
    act_nxt = act_r;
    vid_nxt = pix_i.data;
    unique case (st_r)
      SCC_IDLE: begin
        act_nxt = 1'b0;
        if (line_start_i && cap_line) begin
          // bytes sampled at line start: a write done a line earlier goes out now
          sh_nxt = pix_i.odd_field ? {with_parity(cap_hi_r), with_parity(cap_lo_r)}
                                   : {with_parity(ext_hi_r), with_parity(ext_lo_r)};
          field_odd_nxt = pix_i.odd_field;
          cyc_nxt = 12'h000;
          act_nxt = 1'b1;
          vid_nxt = pix_i.active ? SCC_LVL_BLANK : pix_i.data;
          st_nxt = SCC_WAIT;
        end
      end
      SCC_WAIT: begin
        vid_nxt = pix_i.active ? SCC_LVL_BLANK : pix_i.data;
        cyc_nxt = cyc_r + 12'h001;
        if (cyc_r == SCC_START_CYC) begin
          cyc_nxt = 12'h000;
          cnt_nxt = 5'h00;
          st_nxt = SCC_RUNIN;
        end
      end
      SCC_RUNIN: begin
        vid_nxt = wave;
        cyc_nxt = cyc_r + 12'h001;
        if (cyc_r == SCC_BIT_LAST) begin
          cyc_nxt = 12'h000;
          cnt_nxt = cnt_r + 5'h02;
          if (cnt_r + 5'h02 == SCC_RUNIN_HALF) begin
            cnt_nxt = 5'h00;
            st_nxt = SCC_GAP;
          end
        end
      end
      SCC_GAP: begin
        // two blank bit periods, then the start bit
        vid_nxt = (cnt_r == SCC_GAP_BITS) ? SCC_LVL_HIGH : SCC_LVL_BLANK;
        cyc_nxt = cyc_r + 12'h001;
        if (cyc_r == SCC_BIT_LAST) begin
          cyc_nxt = 12'h000;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == SCC_GAP_BITS) begin
            cnt_nxt = 5'h00;
            st_nxt = SCC_DATA;
          end
        end
      end
      SCC_DATA: begin
        vid_nxt = sh_r[0] ? SCC_LVL_HIGH : SCC_LVL_BLANK;
        cyc_nxt = cyc_r + 12'h001;
        if (cyc_r == SCC_BIT_LAST) begin
          cyc_nxt = 12'h000;
          sh_nxt = {1'b0, sh_r[15:1]};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == SCC_DATA_BITS - 5'h01) st_nxt = SCC_IDLE;
        end
      end
      default: st_nxt = SCC_IDLE;
    endcase
    // active pixels in the remainder of a caption line after the payload stay blank; inactive ones pass through
    if (st_r == SCC_IDLE && act_r && !line_start_i) begin
      act_nxt = 1'b1;
      vid_nxt = pix_i.active ? SCC_LVL_BLANK : pix_i.data;
    end
    if (st_r == SCC_IDLE && line_start_i && !cap_line) act_nxt = 1'b0;
    if (!en_r) begin
      st_nxt = SCC_IDLE;
      act_nxt = 1'b0;
      vid_nxt = pix_i.data;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= SCC_IDLE;
      cyc_r <= 12'h000;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      field_odd_r <= 1'b0;
      act_r <= 1'b0;
      vid_r <= 10'h000;
    end else begin
      st_r <= st_nxt;
      cyc_r <= cyc_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      field_odd_r <= field_odd_nxt;
      act_r <= act_nxt;
      vid_r <= vid_nxt;
    end
  end

  assign video_o = vid_r;
  assign caption_active_o = act_r;

endmodule

// ===== bench/scc_inserter_checker.sv
// checker: port-level assertions for the caption inserter
module scc_inserter_checker
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire scc_pix_s pix_i,
  input wire logic line_start_i,
  input wire logic [9:0] video_o,
  input wire logic caption_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = avs_read_i | avs_write_i;
  wait_one_a: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("access not answered after one cycle");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  rd_upper_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  rd_stand_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  cap_line_a: assert property ($rose(caption_active_o) |-> $past(line_start_i) &&
    ($past(pix_i.odd_field) ? $past(pix_i.line) == SCC_LINE_ODD : $past(pix_i.line) == SCC_LINE_EVEN))
    else $error("caption started on wrong line");
  non_cap_a: assert property (line_start_i && pix_i.line != SCC_LINE_ODD &&
    pix_i.line != SCC_LINE_EVEN |=> !caption_active_o) else $error("caption on other line");
  pass_thru_a: assert property (!caption_active_o && !$past(rst_i) |->
    video_o == $past(pix_i.data)) else $error("pixel data not passed through");
  cap_level_a: assert property (caption_active_o |->
    video_o >= SCC_LVL_BLANK && video_o <= SCC_LVL_HIGH) else $error("pixel leaked into caption");
  act_hold_a: assert property (caption_active_o && !line_start_i |=> caption_active_o)
    else $error("caption line dropped early");
  cover property (avs_write_i && !avs_waitrequest_o);
  cover property ($rose(caption_active_o) && $past(pix_i.odd_field));
  cover property ($rose(caption_active_o) && !$past(pix_i.odd_field));
endmodule

bind scc_inserter scc_inserter_checker scc_inserter_checker_i (.clk_i, .rst_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .pix_i, .line_start_i, .video_o,
  .caption_active_o);

// ===== bench/scc_rx.sv
// receiver model: slices caption bits at mid-bit from the video samples
module scc_rx
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic line_start_i,
  input wire logic [9:0] video_i,
  output logic start_o,
  output logic [15:0] bits_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int n;
  // mid-bit slicing tolerates half a bit of offset error
  always @(posedge clk_i) begin
    cnt = line_start_i ? 0 : cnt + 1;
    n = cnt - int'(SCC_START_CYC) - 1 - SCC_BIT_CYC / 2;
    if (n >= 0 && n % SCC_BIT_CYC == 0) begin
      n = n / SCC_BIT_CYC;
      if (n == 9) start_o <= video_i > SCC_LVL_MID;
      else if (n >= 10 && n < 26) bits_o[n - 10] <= video_i > SCC_LVL_MID;
    end
  end
endmodule

// ===== bench/tb.sv
// testbench: register access and caption lines against a byte model
module tb;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, ls = 0, wt, act, sb;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdat, got;
  scc_pix_s pix = '0;
  logic [9:0] vid;
  logic [15:0] bits;
  logic [7:0] regs [4];
  int num_errors = 0, num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  scc_inserter scc_inserter_i (.clk_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hf), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .pix_i(pix), .line_start_i(ls), .video_o(vid),
    .caption_active_o(act));
  scc_rx scc_rx_i (.clk_i, .line_start_i(ls), .video_i(vid), .start_o(sb), .bits_o(bits));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // design outputs move by nba, so right after the edge they still show the sampled values
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk_i); while (wt !== 1'b0 && ++k < 50);
    got = rdat;
    rd <= 0;
    wr <= 0;
    if (k >= 50) num_errors++;
  endtask
  task automatic cap_line(logic odd, logic [9:0] ln, logic en, logic [7:0] lo, logic [7:0] hi);
    logic [15:0] e;
    e = {~^hi[6:0], hi[6:0], ~^lo[6:0], lo[6:0]};
    @(posedge clk_i);
    pix.line <= ln; pix.odd_field <= odd; pix.active <= 1; ls <= 1;
    @(posedge clk_i);
    ls <= 0;
    repeat (en ? SCC_START_CYC + 27 * SCC_BIT_CYC : 60) @(posedge clk_i) pix.data <= 10'($urandom);
    check("active", {31'h0, act}, {31'h0, en});
    if (en) begin
      check("start", {31'h0, sb}, 32'h1);
      check("payload", {16'h0, bits}, {16'h0, e});
    end
  endtask
  initial begin
    #500_000;
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h143fa976));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 4; i++) begin
      bus(0, SCC_IDX_EXT_LO + 8'(i), 0);
      check("reset", got, {24'h0, SCC_BYTE_RST});
    end
    bus(0, 8'h20, 0);
    check("unmapped", got, SCC_UNMAPPED_RD);
    bus(1, SCC_IDX_CTRL, 32'h1);
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 4; i++) begin
        regs[i] = (t == 1) ? 8'h00 : 8'($urandom);
        bus(1, SCC_IDX_EXT_LO + 8'(i), {24'h0, regs[i]});
        bus(0, SCC_IDX_EXT_LO + 8'(i), 0);
        check("byte reg", got, {24'h0, regs[i]});
      end
      cap_line(1, SCC_LINE_ODD, 1, regs[2], regs[3]);
      cap_line(0, SCC_LINE_EVEN, 1, regs[0], regs[1]);
    end
    cap_line(1, SCC_LINE_EVEN, 0, 0, 0);
    cap_line(0, 10'd20, 0, 0, 0);
    bus(1, SCC_IDX_CTRL, 32'h0);
    cap_line(1, SCC_LINE_ODD, 0, 0, 0);
    complete_run();
  end
endmodule
